// ### src/sart_pkg.sv
package sart_pkg;

    // special-function-register map, all on register page F
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h91;
    localparam logic [7:0] ADDR_RELOAD_LOW    = 8'h92;
    localparam logic [7:0] ADDR_RELOAD_HIGH   = 8'h93;
    localparam logic [7:0] ADDR_COUNT_LOW     = 8'h94;
    localparam logic [3:0] REG_PAGE           = 4'hf;

    // timer_control field positions
    localparam int BIT_HIGH_FLAG   = 7;
    localparam int BIT_LOW_FLAG    = 6;
    localparam int BIT_LOW_IRQ_EN  = 5;
    localparam int BIT_SPLIT       = 3;
    localparam int BIT_RUN         = 2;
    localparam int BIT_EXT_CLK     = 0;
    // writable bits; 4 and 1 read zero and ignore writes
    localparam logic [7:0] CONTROL_WRITE_MASK = 8'hed;

    // reset values
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [7:0] RESET_BYTE    = 8'h00;

    // clock dividers: system clock cycles per tick, and external clock rising edges per tick
    localparam int SYS_DIV = 12;
    localparam int EXT_DIV = 8;

    // special-function-register access from the core
    typedef struct packed {
        logic       write;
        logic       read;
        logic [3:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sart_sfr_req_t;

    // per-half clock selects from the clock configuration register
    typedef struct packed {
        logic high_half_clock_select;
        logic low_half_clock_select;
    } sart_clk_sel_t;

endpackage

// ### src/sart_tick_gen.sv
`timescale 1ns/1ps
// divided tick pulses: system clock / 12 and external clock / 8
module sart_tick_gen #(
    parameter int SYS_DIVIDE = sart_pkg::SYS_DIV,
    parameter int EXT_DIVIDE = sart_pkg::EXT_DIV
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // external clock, already synchronous to the system clock
    input  wire logic ext_clock,
    // one-cycle tick pulses
    output logic      sys_tick,
    output logic      ext_tick
);
    localparam int SW = $clog2(SYS_DIVIDE);
    localparam int EW = $clog2(EXT_DIVIDE);

    // a divider below two could never drop its pulse, so refuse it at elaboration
    if (SYS_DIVIDE < 2 || EXT_DIVIDE < 2) begin : g_bad_divide
        $error("sart_tick_gen: dividers must be at least 2");
    end

    logic [SW-1:0] sys_cnt_reg;
    logic [EW-1:0] ext_cnt_reg;
    logic          ext_last_reg;
    logic          ext_rise;

    assign ext_rise = ext_clock && !ext_last_reg;

    // system divider: free-running, one pulse per SYS_DIVIDE cycles
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sys_cnt_reg <= '0;
            sys_tick    <= 1'b0;
        end else if (sys_cnt_reg == SW'(SYS_DIVIDE - 1)) begin
            sys_cnt_reg <= '0;
            sys_tick    <= 1'b1;                    // [R17]
        end else begin
            sys_cnt_reg <= sys_cnt_reg + 1'b1;
            sys_tick    <= 1'b0;
        end
    end

    // external divider counts rising edges so the tick lands in this domain
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ext_last_reg <= 1'b0;
            ext_cnt_reg  <= '0;
            ext_tick     <= 1'b0;
        end else begin
            ext_last_reg <= ext_clock;
            ext_tick     <= 1'b0;
            if (ext_rise) begin
                if (ext_cnt_reg == EW'(EXT_DIVIDE - 1)) begin
                    ext_cnt_reg <= '0;
                    ext_tick    <= 1'b1;            // [R9]
                end else begin
                    ext_cnt_reg <= ext_cnt_reg + 1'b1;
                end
            end
        end
    end
endmodule

// ### src/sart_timer.sv
`timescale 1ns/1ps
// Functional notes
// R1: the high overflow flag sets when the high byte wraps 0xFF to 0x00, i.e. a 0xFFFF wrap in 16-bit mode.
// R2: with the timer interrupt enabled, a set high overflow flag requests the interrupt.
// R3: the low overflow flag sets on every low byte wrap 0xFF to 0x00 in either mode.
// R4: hardware never clears either flag; software clears them by writing.
// R5: with bit 5 set and the timer interrupt enabled, each low byte overflow raises the interrupt.
// R6: control bits 4 and 1 read as zero and ignore writes.
// R7: bit 3 selects one 16-bit timer (0) or two 8-bit timers (1).
// R8: bit 2 enables counting; in split mode it gates only the high half, the low half always runs.
// R9: bit 0 picks system clock / 12 (0) or external clock / 8 synchronised (1).
// R10: per-half clock selects can override that choice with the undivided system clock.
// R11: reload low and high bytes are read-write at 0x92 and 0x93.
// R12: the count low byte register at 0x94 shows the low count byte and is writable.
// R13: control sits at 0x91 on page F and all these registers reset to zero.
// R14: in 16-bit mode a full wrap loads the 16-bit reload value as the high flag sets.
// R15: in split mode each half reloads from its own reload byte on overflow.
// R16: a per-half select of 1 gives the system clock, 0 gives the external-select source.
// R17: each enabled counter increments by one per tick of its selected source.
module sart_timer #(
    parameter int SYS_DIVIDE = sart_pkg::SYS_DIV,
    parameter int EXT_DIVIDE = sart_pkg::EXT_DIV
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    // special-function-register port
    input  wire sart_pkg::sart_sfr_req_t sfr_req,
    output logic [7:0]                 sfr_rdata,
    // clock configuration and external clock
    input  wire sart_pkg::sart_clk_sel_t clk_sel,
    input  wire logic                  ext_clock,
    // interrupt controller side
    input  wire logic                  timer_irq_enable,
    output logic                       timer_irq,
    // high byte of the count, for the neighbouring register
    output logic [7:0]                 count_high_byte
);
    // limitation: the high count byte is only mirrored out; its register
    // and write path live in the neighbouring block
    // register state
    logic [7:0] control_reg;
    logic [7:0] reload_low_byte_reg;
    logic [7:0] reload_high_byte_reg;
    logic [7:0] count_low_byte_reg;
    logic [7:0] count_high_reg;
    logic [7:0] control_next;
    // tick sources and per-half selection
    logic       sys_tick;
    logic       ext_tick;
    logic       div_tick;
    logic [1:0] half_sel;
    logic [1:0] half_tick;
    logic       low_tick;
    logic       high_tick;
    // run and wrap qualifiers
    logic       split;
    logic       low_run;
    logic       high_run;
    logic       low_wrap;
    logic       high_wrap;
    // decoded write strobes
    logic       wr_control;
    logic       wr_reload_low;
    logic       wr_reload_high;
    logic       wr_count_low;

    // a divider below two could never drop its pulse, so refuse it outright
    if (SYS_DIVIDE < 2 || EXT_DIVIDE < 2) begin : g_bad_divide
        $error("sart_timer: both tick dividers must be at least 2");
    end

    // decode one register of page F
    function automatic logic hit(input sart_pkg::sart_sfr_req_t r, input logic [7:0] a);
        return r.page == sart_pkg::REG_PAGE && r.addr == a;
    endfunction

    // the dividers run free, so the first tick after a mode change has no fixed phase
    sart_tick_gen #(
        .SYS_DIVIDE(SYS_DIVIDE),
        .EXT_DIVIDE(EXT_DIVIDE)
    ) sart_tick_gen_i (
        .clock    (clock),
        .reset_n  (reset_n),
        .ext_clock(ext_clock),
        .sys_tick (sys_tick),
        .ext_tick (ext_tick)
    );

    // write strobes, decoded once so every register block sees one name
    assign wr_control     = sfr_req.write && hit(sfr_req, sart_pkg::ADDR_TIMER_CONTROL);
    assign wr_reload_low  = sfr_req.write && hit(sfr_req, sart_pkg::ADDR_RELOAD_LOW);
    assign wr_reload_high = sfr_req.write && hit(sfr_req, sart_pkg::ADDR_RELOAD_HIGH);
    assign wr_count_low   = sfr_req.write && hit(sfr_req, sart_pkg::ADDR_COUNT_LOW);

    // clock source per half: undivided clock ticks every cycle
    assign div_tick  = control_reg[sart_pkg::BIT_EXT_CLK] ? ext_tick : sys_tick;  // [R9]
    assign half_sel  = {clk_sel.high_half_clock_select, clk_sel.low_half_clock_select};

    // index 0 is the low half, index 1 the high half; each override stands alone
    for (genvar h = 0; h < 2; h++) begin : g_half_src
        assign half_tick[h] = half_sel[h] ? 1'b1 : div_tick;                       // [R10] [R16]
    end
    assign low_tick  = half_tick[0];
    assign high_tick = half_tick[1];

    // in 16-bit mode the whole counter uses the low half's source
    assign split    = control_reg[sart_pkg::BIT_SPLIT];                            // [R7]
    assign low_run  = low_tick && (split || control_reg[sart_pkg::BIT_RUN]);      // [R8]
    assign high_run = split ? (high_tick && control_reg[sart_pkg::BIT_RUN])       // [R8]
                            : (low_run && count_low_byte_reg == 8'hff);
    assign low_wrap  = low_run && count_low_byte_reg == 8'hff;                     // [R3]
    assign high_wrap = high_run && count_high_reg == 8'hff;                        // [R1]

    // low counter byte; software write wins over a count in the same cycle
    // limitation: a write in a 16-bit wrap cycle still carries into the high byte
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count_low_byte_reg <= sart_pkg::RESET_BYTE;                            // [R13]
        end else if (wr_count_low) begin
            count_low_byte_reg <= sfr_req.wdata;                                   // [R12]
        end else if (low_wrap && (split || high_wrap)) begin
            count_low_byte_reg <= reload_low_byte_reg;                             // [R14] [R15]
        end else if (low_run) begin
            count_low_byte_reg <= count_low_byte_reg + 8'h01;                      // [R17]
        end
    end

    // high counter byte; its register lies outside this block so it only counts
    // in 16-bit mode it steps on the low byte's wrap, never on its own tick
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count_high_reg <= sart_pkg::RESET_BYTE;
        end else if (high_wrap) begin
            count_high_reg <= reload_high_byte_reg;                                // [R14] [R15]
        end else if (high_run) begin
            count_high_reg <= count_high_reg + 8'h01;                              // [R17]
        end
    end

    // reload registers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            reload_low_byte_reg  <= sart_pkg::RESET_BYTE;                          // [R13]
            reload_high_byte_reg <= sart_pkg::RESET_BYTE;
        end else begin
            if (wr_reload_low) begin
                reload_low_byte_reg <= sfr_req.wdata;                              // [R11]
            end
            if (wr_reload_high) begin
                reload_high_byte_reg <= sfr_req.wdata;                             // [R11]
            end
        end
    end

    // control: a software write applies first, then hardware sets flags on top
    // so an overflow in the clearing cycle is never lost
    always_comb begin
        control_next = control_reg;
        if (wr_control) begin                                                      // [R13]
            control_next = sfr_req.wdata & sart_pkg::CONTROL_WRITE_MASK;           // [R6] [R4]
        end
        if (high_wrap) begin
            control_next[sart_pkg::BIT_HIGH_FLAG] = 1'b1;                          // [R1]
        end
        if (low_wrap) begin
            control_next[sart_pkg::BIT_LOW_FLAG] = 1'b1;                           // [R3]
        end
    end

    // control register; bits 4 and 1 stay zero because the mask never sets them
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            control_reg <= sart_pkg::RESET_CONTROL;                                // [R13]
        end else begin
            control_reg <= control_next;                                           // [R4]
        end
    end

    // interrupt request level follows the flags, registered
    // built from the next flag values so the request rises with the flag itself
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= timer_irq_enable &&
                         (control_next[sart_pkg::BIT_HIGH_FLAG] ||                 // [R2]
                          (control_next[sart_pkg::BIT_LOW_IRQ_EN] &&
                           control_next[sart_pkg::BIT_LOW_FLAG]));                 // [R5]
        end
    end

    // registered read data; unmapped addresses read zero
    // reads have no side effects, so polling the flags never loses one
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
        end else if (!sfr_req.read) begin
            sfr_rdata <= 8'h00;
        end else if (hit(sfr_req, sart_pkg::ADDR_TIMER_CONTROL)) begin
            sfr_rdata <= control_reg;                                              // [R6]
        end else if (hit(sfr_req, sart_pkg::ADDR_RELOAD_LOW)) begin
            sfr_rdata <= reload_low_byte_reg;
        end else if (hit(sfr_req, sart_pkg::ADDR_RELOAD_HIGH)) begin
            sfr_rdata <= reload_high_byte_reg;
        end else if (hit(sfr_req, sart_pkg::ADDR_COUNT_LOW)) begin
            sfr_rdata <= count_low_byte_reg;                                       // [R12]
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // high count is a flip-flop output already
    // it takes the counter's next value, so both agree at every edge
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count_high_byte <= 8'h00;
        end else begin
            count_high_byte <= high_wrap ? reload_high_byte_reg
                             : high_run ? count_high_reg + 8'h01 : count_high_reg;
        end
    end
endmodule

// ### bench/sart_properties.sv
`timescale 1ns/1ps
// port-level checks on the split timer; all in the system clock domain
module sart_properties (
    // clock and reset
    input wire logic                    clock,
    input wire logic                    reset_n,
    // register port
    input wire sart_pkg::sart_sfr_req_t sfr_req,
    input wire logic [7:0]              sfr_rdata,
    // interrupt side
    input wire logic                    timer_irq_enable,
    input wire logic                    timer_irq,
    input wire logic [7:0]              count_high_byte
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // an access only counts on the right page
    logic on_page;
    logic ctrl_wr;
    assign on_page = sfr_req.page == sart_pkg::REG_PAGE;
    assign ctrl_wr = sfr_req.write && on_page && sfr_req.addr == 8'h91;
    sequence wr_at(a);
        sfr_req.write && on_page && sfr_req.addr == a;
    endsequence
    sequence rd_at(a);
        sfr_req.read && !sfr_req.write && on_page && sfr_req.addr == a;
    endsequence
    a_ctrl_gaps: assert property (rd_at(8'h91) |=> !sfr_rdata[4] && !sfr_rdata[1])
        else $error("control gap bits read nonzero");
    a_ctrl_back: assert property ((wr_at(8'h91) ##1 rd_at(8'h91)) |=>
        (sfr_rdata & 8'h2d) == ($past(sfr_req.wdata, 2) & 8'h2d))
        else $error("control readback wrong");
    a_reload_back: assert property ((wr_at(8'h92) ##1 rd_at(8'h92)) |=>
        sfr_rdata == $past(sfr_req.wdata, 2))
        else $error("reload readback wrong");
    a_count_back: assert property ((wr_at(8'h94) ##1 rd_at(8'h94)) |=>
        sfr_rdata == $past(sfr_req.wdata, 2))
        else $error("count low readback wrong");
    a_page_refused: assert property (sfr_req.read && !on_page |=> sfr_rdata == 8'h00)
        else $error("foreign page answered");
    a_rdata_idle: assert property (!sfr_req.read |=> sfr_rdata == 8'h00)
        else $error("read data without read");
    a_irq_gated: assert property (!timer_irq_enable |=> !timer_irq)
        else $error("interrupt while disabled");
    // the interrupt only drops through a control write or a withdrawn enable
    a_irq_held: assert property ($fell(timer_irq) |-> !$past(timer_irq_enable) ||
        $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
        else $error("interrupt dropped by itself");
    a_reset_clear: assert property ($rose(reset_n) |->
        count_high_byte == 8'h00 && !timer_irq && sfr_rdata == 8'h00)
        else $error("outputs not clear after reset");
endmodule
bind sart_timer sart_properties sart_properties_i (.clock(clock), .reset_n(reset_n),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq),
    .count_high_byte(count_high_byte));

// ### bench/sart_timer_bench.sv
`timescale 1ns/1ps
module sart_timer_bench;
    logic                    clock = 1'b0;
    logic                    reset_n = 1'b0;
    sart_pkg::sart_sfr_req_t sfr_req = '0;
    logic [7:0]              sfr_rdata;
    sart_pkg::sart_clk_sel_t clk_sel = '0;
    logic                    ext_clock = 1'b0;
    logic                    timer_irq_enable = 1'b0;
    logic                    timer_irq;
    logic [7:0]              count_high_byte;
    int                      err_total = 0;
    int                      n_tests = 0;
    int                      seed = 80666;
    int                      cyc = 0;
    int                      p;
    logic [7:0]              v, rl, rh;
    logic                    x;

    sart_timer sart_timer_i (.clock(clock), .reset_n(reset_n), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .clk_sel(clk_sel), .ext_clock(ext_clock),
        .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq),
        .count_high_byte(count_high_byte));

    // system clock, and an external clock at half its rate
    always #12.5 clock = ~clock;
    always @(negedge clock) ext_clock <= ~ext_clock;

    // the sequence needs about 1300 cycles, so this only trips on a hang
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string what);
        n_tests++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    // one access per cycle, launched on the falling edge, page F
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{w, !w, 4'hf, a, d};
        @(negedge clock);
    endtask
    task automatic rd(input logic [7:0] a);
        acc(1'b0, a, 8'h00);
        v = sfr_rdata;
    endtask
    task automatic wt(input int n);
        sfr_req = '0;
        repeat (n) @(negedge clock);
    endtask

    // ticks over a window; the divider phase is free, hence the slack
    function automatic logic in_win(input logic [7:0] c, input int win, input int per);
        return c >= win / per - 2 && c <= win / per + 2;
    endfunction

    initial begin
        repeat (6) @(negedge clock);
        reset_n = 1'b1;
        for (int a = 8'h91; a <= 8'h95; a++) begin
            rd(a[7:0]);
            chk(v === 8'h00, "reset value");
        end
        // a write and a read on a foreign page are ignored
        sfr_req = '{1'b1, 1'b0, 4'h0, 8'h92, 8'ha5};
        @(negedge clock);
        sfr_req = '{1'b0, 1'b1, 4'h0, 8'h92, 8'h00};
        @(negedge clock);
        chk(sfr_rdata === 8'h00, "foreign page read");
        rd(8'h92);
        chk(v === 8'h00, "foreign page write");
        acc(1'b1, 8'h91, 8'hff);
        rd(8'h91);
        chk(v === 8'hed, "control gaps");
        rl = 8'($random(seed)) & 8'h7f;
        rh = 8'($random(seed));
        acc(1'b1, 8'h91, 8'h00);
        acc(1'b1, 8'h92, rl);
        rd(8'h92);
        chk(v === rl, "reload low");
        acc(1'b1, 8'h93, 8'hff);
        rd(8'h93);
        chk(v === 8'hff, "reload high");
        // split: low half runs alone while the run bit is clear
        clk_sel = 2'b11;
        acc(1'b1, 8'h91, 8'h08);
        wt(300);
        chk(count_high_byte === 8'h00, "high ran unbidden");
        rd(8'h94);
        chk(v >= rl, "low reload");
        rd(8'h91);
        chk(v === 8'h48, "low flag");
        acc(1'b1, 8'h91, 8'h0c);
        wt(300);
        chk(count_high_byte === 8'hff, "high reload");
        rd(8'h91);
        chk(v === 8'hcc, "high flag");
        // stopped: flags stay until software writes them
        acc(1'b1, 8'h91, 8'hc0);
        timer_irq_enable = 1'b1;
        wt(50);
        chk(timer_irq === 1'b1, "irq on high flag");
        rd(8'h91);
        chk(v === 8'hc0, "flags kept");
        acc(1'b1, 8'h91, 8'h00);
        wt(4);
        chk(timer_irq === 1'b0, "flags cleared");
        acc(1'b1, 8'h91, 8'h60);
        wt(4);
        chk(timer_irq === 1'b1, "low irq enabled");
        acc(1'b1, 8'h91, 8'h40);
        wt(4);
        chk(timer_irq === 1'b0, "low irq masked");
        // 16-bit: 0xfff0 wraps after 16 ticks and reloads {rh, rl}
        acc(1'b1, 8'h93, rh);
        acc(1'b1, 8'h94, 8'hf0);
        rd(8'h94);
        chk(v === 8'hf0, "count low write");
        acc(1'b1, 8'h91, 8'h04);
        wt(40);
        chk(count_high_byte === rh && timer_irq === 1'b1, "16-bit reload");
        rd(8'h91);
        chk(v === 8'hc4, "16-bit flags");
        // sources: system_clock/12, external/8 at 2 cycles a period, undivided
        for (int m = 0; m < 3; m++) begin
            clk_sel = {m == 2, m == 2};
            p = (m == 0) ? 12 : (m == 1) ? 16 : 1;
            x = (m == 1) | ((m == 2) & 1'($random(seed)));
            acc(1'b1, 8'h91, {7'h02, x});
            acc(1'b1, 8'h94, 8'h00);
            wt(192);
            rd(8'h94);
            chk(in_win(v, 192, p), "tick rate");
        end
        wt(2);
        end_of_test();
    end
endmodule
